//--- status_ind_pkg.sv
// Purpose: Shared constants and types for the scanner status indicator.
// Assumes: One 25 MHz core clock; AXI4-Lite register access.
// Notes:   Counts are derived from times here; long counts are top parameters.
`default_nettype none
package status_ind_pkg;
	// Core clock rate and the times that matter to the indicators
	localparam longint CLK_HZ            = 25_000_000;
	localparam longint BLANK_TIME_S      = 60;
	localparam longint BLANK_CYCLES      = BLANK_TIME_S * CLK_HZ;
	localparam longint BLINK_HALF_MS     = 250;
	localparam longint BLINK_HALF_CYCLES = (BLINK_HALF_MS * CLK_HZ) / 1000;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DISP   = 8'h08;

	// Control register fields, writable mask and reset value
	localparam int          CTRL_CFG_LSB    = 0;
	localparam int          CTRL_MANUAL_BIT = 2;
	localparam int          CTRL_TIMED_BIT  = 3;
	localparam int          CTRL_PAGES_LSB  = 8;
	localparam logic [31:0] CTRL_MASK       = 32'h0000_0f0f;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0105;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Symbol shown in the main display area
	typedef enum logic [3:0] {
		SYM_CLEAR     = 4'h0,
		SYM_FIELD     = 4'h1,
		SYM_READY     = 4'h2,
		SYM_PRESS_OFF = 4'h3,
		SYM_PRESS_ON  = 4'h4,
		SYM_COUNTDOWN = 4'h5,
		SYM_WARN      = 4'h6,
		SYM_FAULT     = 4'h7
	} sym_t;

	// Display states, one-hot
	typedef enum logic [2:0] {
		DISP_OFF     = 3'h1,
		DISP_SUMMARY = 3'h2,
		DISP_DETAIL  = 3'h4
	} disp_state_t;
endpackage
`default_nettype wire

//--- blink_if.sv
// Purpose: Carries the common blink phase from the divider to its users.
// Assumes: Both ends sit on the core clock.
// Notes:   One phase for every flashing element keeps them all in step.
`timescale 1ns/1ps
`default_nettype none
interface blink_if;
	logic phase; // High during the lit half of a blink period
	modport src (output phase);
	modport dst (input  phase);
endinterface
`default_nettype wire

//--- blink_divider.sv
// Purpose: Fixed divider producing the common blink phase.
// Assumes: HALF_COUNT is at least one cycle.
// Notes:   Phase toggles once every HALF_COUNT core cycles.
`timescale 1ns/1ps
`default_nettype none
module blink_divider #(
	parameter logic [31:0] HALF_COUNT = 32'(status_ind_pkg::BLINK_HALF_CYCLES)
) (
	input  wire logic i_core_clk, // Core clock
	input  wire logic i_rstn,     // Asynchronous reset, active low
	blink_if.src      o_blink     // Common blink phase
);
	// Divider state
	typedef struct packed {
		logic [31:0] cnt;   // Cycles into the current half period
		logic        phase; // Current blink phase
	} div_t;

	div_t st;      // Registered state
	div_t next_st; // Next state

	// Count a half period, then flip the phase
	always_comb begin
		next_st = st;
		if (st.cnt >= HALF_COUNT - 32'h1) begin
			next_st.cnt   = 32'h0;
			next_st.phase = ~st.phase;
		end else begin
			next_st.cnt = st.cnt + 32'h1;
		end
	end

	// State register
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_blink.phase = st.phase;
endmodule
`default_nettype wire

//--- status_indicator.sv
// Purpose: Drives the status LEDs and the paged status display of the scanner.
// Assumes: Safety states arrive from logic on the core clock; button and
//          Ethernet link/traffic arrive from pins and are synchronised here.
// Notes:   Display content is a symbol code plus fields for the panel driver.
// Function
// - Red steady when field interruption switches output off
// - Red blinks when output off from fault
// - Green lit when any configured output is on
// - Yellow blinks while restart interlock triggered, manual
// - Yellow lit while timed restart delay runs
// - Yellow steady when any warning field interrupted
// - Network LED green once Ethernet link is up
// - Network LED blinks yellow during data traffic
// - Display blanks after 60 s when idle
// - Press on blank display only wakes it
// - Press on active display opens details
// - Page indicator shown; press advances one page
// - Show monitoring case when clear and on
// - Two outputs get own columns showing off
// - Mark on and clear outputs with number
// - Unconfigured outputs stay unmarked on display
// - Show ready-for-reset symbol when field clear
// - Separate reset-pressed symbols for off and on
// - Countdown symbol while timed restart delay runs
// - Warning view shows interrupted and total counts
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module status_indicator #(
	parameter logic [31:0] BLANK_COUNT = 32'(status_ind_pkg::BLANK_CYCLES),
	parameter logic [31:0] BLINK_COUNT = 32'(status_ind_pkg::BLINK_HALF_CYCLES)
) (
	input  wire logic       i_core_clk,       // Core clock, 25 MHz
	input  wire logic       i_rstn,           // Asynchronous reset, active low
	// AXI4-Lite slave
	input  wire logic [7:0] i_s_axi_awaddr,   // Write address
	input  wire logic       i_s_axi_awvalid,  // Write address valid
	output logic            o_s_axi_awready,  // Write address ready
	input  wire logic [31:0] i_s_axi_wdata,   // Write data
	input  wire logic [3:0] i_s_axi_wstrb,    // Write byte strobes
	input  wire logic       i_s_axi_wvalid,   // Write data valid
	output logic            o_s_axi_wready,   // Write data ready
	output logic [1:0]      o_s_axi_bresp,    // Write response
	output logic            o_s_axi_bvalid,   // Write response valid
	input  wire logic       i_s_axi_bready,   // Write response ready
	input  wire logic [7:0] i_s_axi_araddr,   // Read address
	input  wire logic       i_s_axi_arvalid,  // Read address valid
	output logic            o_s_axi_arready,  // Read address ready
	output logic [31:0]     o_s_axi_rdata,    // Read data
	output logic [1:0]      o_s_axi_rresp,    // Read response
	output logic            o_s_axi_rvalid,   // Read data valid
	input  wire logic       i_s_axi_rready,   // Read data ready
	// Internal safety states
	input  wire logic [1:0] i_out_on,         // Safety output in ON state
	input  wire logic [1:0] i_pf_int,         // Protective field cut-off path hit
	input  wire logic       i_fault,          // Outputs off due to a fault
	input  wire logic       i_intlk,          // Restart interlock triggered
	input  wire logic       i_rst_pressed,    // Reset button held
	input  wire logic       i_restart_timer,  // Restart delay running
	input  wire logic [3:0] i_warn_cnt,       // Interrupted warning fields
	input  wire logic [3:0] i_warn_total,     // Warning fields in current case
	input  wire logic [3:0] i_case_num,       // Active monitoring case
	// Pins
	input  wire logic       i_eth_link,       // Ethernet link established
	input  wire logic       i_eth_act,        // Ethernet traffic present
	input  wire logic       i_button,         // Display button, high = pressed
	// Indicators
	output logic            o_led_red,        // OFF-state LED
	output logic            o_led_green,      // ON-state LED
	output logic            o_led_yellow,     // Interlock/warning LED
	output logic            o_net_green,      // Network LED green
	output logic            o_net_yellow,     // Network LED yellow
	output logic            o_disp_on,        // Display lit
	output logic            o_disp_detail,    // Detail pages shown
	output logic [3:0]      o_disp_sym,       // Main symbol code
	output logic            o_disp_flash,     // Display flash phase
	output logic [1:0]      o_disp_col_off,   // Column shows off
	output logic [1:0]      o_disp_col_mark,  // Column marked with number
	output logic            o_disp_case_show, // Show case number
	output logic [3:0]      o_disp_case,      // Case number
	output logic [3:0]      o_disp_warn_left, // Interrupted warning count
	output logic [3:0]      o_disp_warn_right,// Total warning count
	output logic            o_disp_page_show, // Show page indicator
	output logic [3:0]      o_disp_page       // Current detail page
);
	// Complete module state
	typedef struct packed {
		logic [2:0]                 sync1;     // First sync stage
		logic [2:0]                 sync2;     // Second sync stage
		logic                       btn_prev;  // Button, one cycle old
		logic [31:0]                ctrl;      // Control register
		status_ind_pkg::disp_state_t disp;     // Display state
		logic                       disp_on;   // Display lit
		logic [31:0]                idle_cnt;  // Idle cycles before blanking
		logic [3:0]                 page;      // Detail page
		logic                       page_show; // Page indicator on
		logic                       led_red;
		logic                       led_green;
		logic                       led_yellow;
		logic                       net_green;
		logic                       net_yellow;
		status_ind_pkg::sym_t       sym;       // Symbol shown
		logic                       flash;     // Display flash phase
		logic [1:0]                 col_off;
		logic [1:0]                 col_mark;
		logic                       case_show;
		logic [3:0]                 case_num;
		logic [3:0]                 warn_left;
		logic [3:0]                 warn_right;
		logic                       awready;
		logic                       wready;
		logic                       aw_hold;   // Write address captured
		logic                       w_hold;    // Write data captured
		logic [7:0]                 aw_addr;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} st_t;

	st_t         st;         // Registered state
	st_t         next_st;    // Next state
	logic        phase;      // Common blink phase
	logic        press;      // Button press event
	logic        link;       // Synced link level
	logic        act;        // Synced traffic level
	logic [1:0]  cfg;        // Configured outputs
	logic        manual;     // Manual reset configured
	logic        timed;      // Timed restart configured
	logic [3:0]  pages;      // Detail page count
	logic [1:0]  on_cfg;     // Configured outputs that are on
	logic [1:0]  pf_cfg;     // Configured paths with field hit
	logic        warn;       // Any warning field hit
	logic        notify;     // Something other than all clear
	logic        timeout;    // Idle time used up
	logic [1:0]  wsel;       // Decoded write register
	logic [1:0]  rsel;       // Decoded read register
	logic [31:0] merged;     // Control value after strobes

	blink_if blink ();

	// One divider feeds every flashing element
	blink_divider #(
		.HALF_COUNT(BLINK_COUNT)
	) i_blink_divider (
		.i_core_clk(i_core_clk),
		.i_rstn    (i_rstn),
		.o_blink   (blink)
	);
	assign phase = blink.phase;

	// Register decode: 1 control, 2 status, 3 display, 0 unmapped
	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		logic [7:0] word;
		word = {addr[7:2], 2'h0};
		if (word == status_ind_pkg::ADDR_CTRL) begin
			reg_sel = 2'h1;
		end else if (word == status_ind_pkg::ADDR_STATUS) begin
			reg_sel = 2'h2;
		end else if (word == status_ind_pkg::ADDR_DISP) begin
			reg_sel = 2'h3;
		end else begin
			reg_sel = 2'h0;
		end
	endfunction

	// Next-state logic for indicators, display and bus
	always_comb begin
		next_st = st;
		// Pin synchronisers; only the second stage is looked at
		next_st.sync1    = {i_eth_act, i_eth_link, i_button};
		next_st.sync2    = st.sync1;
		next_st.btn_prev = st.sync2[0];
		press  = st.sync2[0] & ~st.btn_prev;
		link   = st.sync2[1];
		act    = st.sync2[2];
		// Configuration from the control register
		cfg    = st.ctrl[status_ind_pkg::CTRL_CFG_LSB +: 2];
		manual = st.ctrl[status_ind_pkg::CTRL_MANUAL_BIT];
		timed  = st.ctrl[status_ind_pkg::CTRL_TIMED_BIT];
		pages  = st.ctrl[status_ind_pkg::CTRL_PAGES_LSB +: 4];
		on_cfg = cfg & i_out_on;
		pf_cfg = cfg & i_pf_int;
		warn   = (i_warn_cnt != 4'h0);

		// Red: a fault flashes, a field cut-off is steady
		if (i_fault) begin
			next_st.led_red = phase;
		end else begin
			next_st.led_red = |(pf_cfg & ~i_out_on);
		end
		next_st.led_green = |on_cfg;

		// Yellow: steady conditions win over the interlock flash
		if (warn) begin
			next_st.led_yellow = 1'b1;
		end else if (timed && i_restart_timer) begin
			next_st.led_yellow = 1'b1;
		end else if (manual && i_intlk) begin
			next_st.led_yellow = phase;
		end else begin
			next_st.led_yellow = 1'b0;
		end

		// Bicolour network LED: traffic flashes yellow over link green
		next_st.net_yellow = link & act & phase;
		next_st.net_green  = link & ~next_st.net_yellow;

		// Symbol priority: fault, warning, reset, field, ready, countdown
		if (i_fault) begin
			next_st.sym = status_ind_pkg::SYM_FAULT;
		end else if (warn) begin
			next_st.sym = status_ind_pkg::SYM_WARN;
		end else if (manual && i_rst_pressed) begin
			if (|on_cfg) begin
				next_st.sym = status_ind_pkg::SYM_PRESS_ON;
			end else begin
				next_st.sym = status_ind_pkg::SYM_PRESS_OFF;
			end
		end else if (|pf_cfg) begin
			next_st.sym = status_ind_pkg::SYM_FIELD;
		end else if (manual && i_intlk) begin
			next_st.sym = status_ind_pkg::SYM_READY;
		end else if (timed && i_restart_timer) begin
			next_st.sym = status_ind_pkg::SYM_COUNTDOWN;
		end else begin
			next_st.sym = status_ind_pkg::SYM_CLEAR;
		end
		next_st.flash = (next_st.sym == status_ind_pkg::SYM_FAULT) & phase;

		// Output columns; unconfigured outputs never show anything
		next_st.col_off  = pf_cfg | (cfg & {2{warn}});
		next_st.col_mark = on_cfg & ~next_st.col_off;
		next_st.warn_left  = i_warn_cnt;
		next_st.warn_right = i_warn_total;
		next_st.case_num   = i_case_num;
		next_st.case_show  = (next_st.sym == status_ind_pkg::SYM_CLEAR)
			&& (cfg != 2'h0) && (on_cfg == cfg);

		// Display state; any notification restarts the idle time
		notify  = (next_st.sym != status_ind_pkg::SYM_CLEAR);
		timeout = (st.idle_cnt >= BLANK_COUNT - 32'h1);
		if (notify || press || st.disp == status_ind_pkg::DISP_OFF) begin
			next_st.idle_cnt = 32'h0;
		end else begin
			next_st.idle_cnt = st.idle_cnt + 32'h1;
		end
		case (st.disp)
			status_ind_pkg::DISP_OFF: begin
				// A press here wakes only, it opens nothing
				if (notify || press) begin
					next_st.disp = status_ind_pkg::DISP_SUMMARY;
				end
			end
			status_ind_pkg::DISP_SUMMARY: begin
				if (press) begin
					next_st.disp = status_ind_pkg::DISP_DETAIL;
					next_st.page = 4'h0;
				end else if (!notify && timeout) begin
					next_st.disp = status_ind_pkg::DISP_OFF;
				end
			end
			status_ind_pkg::DISP_DETAIL: begin
				// Past the last page the summary comes back
				if (press) begin
					if (pages > 4'h1 && st.page < pages - 4'h1) begin
						next_st.page = st.page + 4'h1;
					end else begin
						next_st.disp = status_ind_pkg::DISP_SUMMARY;
						next_st.page = 4'h0;
					end
				end else if (!notify && timeout) begin
					next_st.disp = status_ind_pkg::DISP_OFF;
					next_st.page = 4'h0;
				end
			end
			default: begin
				next_st.disp = status_ind_pkg::DISP_SUMMARY;
			end
		endcase
		next_st.disp_on   = (next_st.disp != status_ind_pkg::DISP_OFF);
		next_st.page_show = (next_st.disp == status_ind_pkg::DISP_DETAIL)
			&& (pages > 4'h1);

		// Write channel: address and data are taken in either order
		if (st.bvalid && i_s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (i_s_axi_awvalid && st.awready) begin
			next_st.aw_hold = 1'b1;
			next_st.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && st.wready) begin
			next_st.w_hold = 1'b1;
			next_st.w_data = i_s_axi_wdata;
			next_st.w_strb = i_s_axi_wstrb;
		end
		wsel   = reg_sel(next_st.aw_addr);
		merged = st.ctrl;
		for (int b = 0; b < 4; b++) begin
			if (next_st.w_strb[b]) begin
				merged[b*8 +: 8] = next_st.w_data[b*8 +: 8];
			end
		end
		if (next_st.aw_hold && next_st.w_hold && !next_st.bvalid) begin
			// Status and display are read-only: writes are accepted and dropped
			if (wsel == 2'h1) begin
				next_st.ctrl = merged & status_ind_pkg::CTRL_MASK;
			end
			next_st.bresp   = (wsel == 2'h0) ? status_ind_pkg::RESP_DECERR
				: status_ind_pkg::RESP_OKAY;
			next_st.bvalid  = 1'b1;
			next_st.aw_hold = 1'b0;
			next_st.w_hold  = 1'b0;
		end
		// Hold off new items while a response is waiting
		next_st.awready = !next_st.aw_hold && !next_st.bvalid;
		next_st.wready  = !next_st.w_hold && !next_st.bvalid;

		// Read channel: one cycle from address to data
		if (st.rvalid && i_s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		rsel = reg_sel(i_s_axi_araddr);
		if (i_s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = status_ind_pkg::RESP_OKAY;
			if (rsel == 2'h1) begin
				next_st.rdata = st.ctrl;
			end else if (rsel == 2'h2) begin
				next_st.rdata = {20'h0, st.page, 1'b0, st.disp[2], st.disp_on,
					st.net_yellow, st.net_green, st.led_yellow, st.led_green,
					st.led_red};
			end else if (rsel == 2'h3) begin
				next_st.rdata = {10'h0, st.warn_right, st.warn_left, st.case_num,
					st.case_show, st.page_show, st.col_mark, st.col_off, st.sym};
			end else begin
				next_st.rdata = 32'h0;
				next_st.rresp = status_ind_pkg::RESP_DECERR;
			end
		end
		next_st.arready = !next_st.rvalid;
	end

	// State register; display starts lit, bus ready from reset
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st         <= '0;
			st.ctrl    <= status_ind_pkg::CTRL_RESET;
			st.disp    <= status_ind_pkg::DISP_SUMMARY;
			st.disp_on <= 1'b1;
			st.awready <= 1'b1;
			st.wready  <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign o_s_axi_awready   = st.awready;
	assign o_s_axi_wready    = st.wready;
	assign o_s_axi_bresp     = st.bresp;
	assign o_s_axi_bvalid    = st.bvalid;
	assign o_s_axi_arready   = st.arready;
	assign o_s_axi_rdata     = st.rdata;
	assign o_s_axi_rresp     = st.rresp;
	assign o_s_axi_rvalid    = st.rvalid;
	assign o_led_red         = st.led_red;
	assign o_led_green       = st.led_green;
	assign o_led_yellow      = st.led_yellow;
	assign o_net_green       = st.net_green;
	assign o_net_yellow      = st.net_yellow;
	assign o_disp_on         = st.disp_on;
	assign o_disp_detail     = st.disp[2];
	assign o_disp_sym        = st.sym;
	assign o_disp_flash      = st.flash;
	assign o_disp_col_off    = st.col_off;
	assign o_disp_col_mark   = st.col_mark;
	assign o_disp_case_show  = st.case_show;
	assign o_disp_case       = st.case_num;
	assign o_disp_warn_left  = st.warn_left;
	assign o_disp_warn_right = st.warn_right;
	assign o_disp_page_show  = st.page_show;
	assign o_disp_page       = st.page;
endmodule
`default_nettype wire

//--- status_indicator_checker.sv
// Purpose: Port-level checks of the status indicator.
// Assumes: Outputs lag the state inputs by one cycle.
// Notes:   up masks early edges where $past still sees reset values.
`timescale 1ns/1ps
`default_nettype none
module status_indicator_checker (
	input wire logic       i_core_clk,       // Clock
	input wire logic       i_rstn,           // Reset
	input wire logic [1:0] i_out_on,         // Outputs on
	input wire logic [1:0] i_pf_int,         // Field hit
	input wire logic       i_fault,          // Fault
	input wire logic       i_restart_timer,  // Delay runs
	input wire logic [3:0] i_warn_cnt,       // Warn count
	input wire logic [3:0] i_case_num,       // Case
	input wire logic       o_led_red,        // Red
	input wire logic       o_led_green,      // Green
	input wire logic       o_led_yellow,     // Yellow
	input wire logic       o_disp_on,        // Lit
	input wire logic       o_disp_detail,    // Detail
	input wire logic [3:0] o_disp_sym,       // Symbol
	input wire logic       o_disp_flash,     // Flash
	input wire logic [1:0] o_disp_col_off,   // Column off
	input wire logic [1:0] o_disp_col_mark,  // Column mark
	input wire logic       o_disp_case_show, // Case shown
	input wire logic [3:0] o_disp_case,      // Case value
	input wire logic [3:0] o_disp_warn_left  // Left count
);
	logic [1:0] up_sr; // Edges since release
	logic       up;    // Past values are real
	// Two stages, so no $past reaches into reset
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) up_sr <= 2'h0;
		else up_sr <= {up_sr[0], 1'h1};
	end
	assign up = up_sr[1];
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	property p_green; up && o_led_green |-> $past(i_out_on) != 2'h0; endproperty
	a_green: assert property (p_green) else $error("green without output on");
	property p_red; up && o_led_red && !$past(i_fault) |-> ($past(i_pf_int) & ~$past(i_out_on)) != 2'h0; endproperty
	a_red: assert property (p_red) else $error("red without field cut");
	property p_yel; up && $past(i_warn_cnt) != 4'h0 |-> o_led_yellow; endproperty
	a_yel: assert property (p_yel) else $error("yellow dark on warning");
	property p_warn; up |-> o_disp_warn_left == $past(i_warn_cnt); endproperty
	a_warn: assert property (p_warn) else $error("warning count wrong");
	property p_case; up && o_disp_case_show |-> o_disp_sym == 4'h0 && o_disp_case == $past(i_case_num); endproperty
	a_case: assert property (p_case) else $error("case shown wrongly");
	property p_mark; up |-> (o_disp_col_mark & (o_disp_col_off | ~$past(i_out_on))) == 2'h0; endproperty
	a_mark: assert property (p_mark) else $error("column mark wrong");
	property p_cnt; up && o_disp_sym == status_ind_pkg::SYM_COUNTDOWN |-> $past(i_restart_timer) && o_led_yellow; endproperty
	a_cnt: assert property (p_cnt) else $error("countdown wrong");
	property p_wake; up && $rose(o_disp_on) |-> !o_disp_detail; endproperty
	a_wake: assert property (p_wake) else $error("wake opened details");
	property p_flash; o_disp_flash |-> o_led_red && o_disp_sym == status_ind_pkg::SYM_FAULT; endproperty
	a_flash: assert property (p_flash) else $error("flash out of phase");
endmodule
bind status_indicator status_indicator_checker i_status_indicator_checker (.*);
`default_nettype wire

//--- status_operator.sv
// Purpose: Operator who presses the display button briefly.
// Assumes: A one-cycle request starts one press.
// Notes:   Four cycles pass the pin synchroniser; released reads low.
`timescale 1ns/1ps
`default_nettype none
module status_operator (
	input  wire logic i_core_clk, // Clock
	input  wire logic i_rstn,     // Reset
	input  wire logic i_press,    // Start a press
	output var logic  o_button    // High = pressed
);
	logic [2:0] hold; // Press cycles left
	// Short press only, as a wake-up or paging press
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) hold <= 3'h0;
		else if (i_press) hold <= 3'h4;
		else if (hold != 3'h0) hold <= hold - 3'h1;
	end
	assign o_button = hold != 3'h0;
endmodule
`default_nettype wire

//--- status_indicator_tb.sv
// Purpose: Self-checking bench for the status indicator.
// Assumes: Short blank (50) and blink (4) counts.
// Notes:   AXI tasks wait on handshakes; a watchdog ends hangs.
`timescale 1ns/1ps
`default_nettype none
module status_indicator_tb;
	logic        i_core_clk = 1'h0, i_rstn = 1'h0, press = 1'h0, i_button;
	logic [7:0]  i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
	logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
	logic [3:0]  i_s_axi_wstrb = 4'hf, i_warn_cnt = 4'h0, i_warn_total = 4'h0, i_case_num = 4'h5;
	logic [1:0]  i_out_on = 2'h0, i_pf_int = 2'h0, o_s_axi_bresp, o_s_axi_rresp, o_disp_col_off, o_disp_col_mark;
	logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic        i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0, i_fault = 1'h0, i_intlk = 1'h0;
	logic        i_rst_pressed = 1'h0, i_restart_timer = 1'h0, i_eth_link = 1'h0, i_eth_act = 1'h0;
	logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic        o_led_red, o_led_green, o_led_yellow, o_net_green, o_net_yellow, o_disp_on, o_disp_detail;
	logic        o_disp_flash, o_disp_case_show, o_disp_page_show;
	logic [3:0]  o_disp_sym, o_disp_case, o_disp_warn_left, o_disp_warn_right, o_disp_page;
	int          n_errors = 0, check_count = 0, n;
	status_indicator #(.BLANK_COUNT(32'h32), .BLINK_COUNT(32'h4)) i_status_indicator (.*);
	status_operator i_status_operator (.i_core_clk, .i_rstn, .i_press(press), .o_button(i_button));
	always #20 i_core_clk = ~i_core_clk;
	task t(input int k);
		repeat (k) @(posedge i_core_clk);
	endtask
	task chk(input logic [35:0] g, input logic [35:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task test_done;
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Write: address and data offered together, each dropped when taken
	task wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge i_core_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		{i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
		do begin
			@(posedge i_core_clk);
			if (o_s_axi_awready === 1'h1) i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready === 1'h1) i_s_axi_wvalid <= 1'h0;
		end while (o_s_axi_bvalid !== 1'h1);
		i_s_axi_bready <= 1'h0;
		chk(o_s_axi_bresp, e);
		t(2);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_core_clk);
		i_s_axi_araddr <= a;
		{i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
		do begin
			@(posedge i_core_clk);
			if (o_s_axi_arready === 1'h1) i_s_axi_arvalid <= 1'h0;
		end while (o_s_axi_rvalid !== 1'h1);
		i_s_axi_rready <= 1'h0;
		chk({o_s_axi_rdata, o_s_axi_rresp}, {e, er});
	endtask
	// Counts changes of red, yellow or network yellow over 24 cycles
	task blk(input int s);
		logic [2:0] v;
		logic       p;
		t(2);
		v = {o_net_yellow, o_led_yellow, o_led_red};
		p = v[s];
		n = 0;
		repeat (24) begin
			@(posedge i_core_clk);
			v = {o_net_yellow, o_led_yellow, o_led_red};
			if (v[s] !== p) n++;
			p = v[s];
		end
	endtask
	task push;
		@(posedge i_core_clk);
		press <= 1'h1;
		@(posedge i_core_clk);
		press <= 1'h0;
		t(8);
	endtask
	// Main sequence
	initial begin
		t(20);
		i_rstn <= 1'h1;
		rdc(8'h00, 32'h105, 2'h0);
		rdc(8'h0c, 32'h0, 2'h3);
		wrc(8'h00, 32'hffffffff, 2'h0);
		rdc(8'h00, 32'hf0f, 2'h0);
		wrc(8'h00, 32'h303, 2'h0);
		i_out_on <= 2'h3;
		t(3);
		chk({o_led_green, o_disp_case_show, o_disp_case, o_disp_col_mark}, 8'hd7);
		{i_pf_int, i_out_on} <= 4'h6;
		blk(0);
		chk({o_led_red, n == 0, o_disp_col_off, o_disp_col_mark}, 6'h36);
		wrc(8'h00, 32'h302, 2'h0);
		{i_pf_int, i_out_on} <= 4'h3;
		t(3);
		chk({o_disp_col_off, o_disp_col_mark}, 4'h2);
		i_fault <= 1'h1;
		blk(0);
		chk({n > 3, o_disp_sym}, {1'h1, status_ind_pkg::SYM_FAULT});
		{i_fault, i_warn_cnt, i_warn_total} <= 9'h025;
		wrc(8'h00, 32'h303, 2'h0);
		chk({o_led_yellow, o_disp_sym, o_disp_warn_left, o_disp_warn_right, o_disp_col_off},
			{1'h1, status_ind_pkg::SYM_WARN, 8'h25, 2'h3});
		{i_warn_cnt, i_restart_timer, i_out_on} <= 7'h04;
		wrc(8'h00, 32'h30b, 2'h0);
		chk({o_led_yellow, o_disp_sym}, {1'h1, status_ind_pkg::SYM_COUNTDOWN});
		{i_restart_timer, i_intlk} <= 2'h1;
		wrc(8'h00, 32'h307, 2'h0);
		blk(1);
		chk({n > 3, o_disp_sym}, {1'h1, status_ind_pkg::SYM_READY});
		i_rst_pressed <= 1'h1;
		t(3);
		chk(o_disp_sym, status_ind_pkg::SYM_PRESS_OFF);
		i_out_on <= 2'h3;
		t(3);
		chk(o_disp_sym, status_ind_pkg::SYM_PRESS_ON);
		{i_intlk, i_rst_pressed, i_eth_link} <= 3'h1;
		t(6);
		chk({o_net_green, o_net_yellow}, 2'h2);
		rdc(8'h04, 32'h2a, 2'h0);
		i_eth_act <= 1'h1;
		blk(2);
		chk(n > 3, 1'h1);
		t(56);
		chk(o_disp_on, 1'h0);
		push;
		chk({o_disp_on, o_disp_detail}, 2'h2);
		push;
		for (int i = 0; i < 3; i++) begin
			chk({o_disp_detail, o_disp_page_show, o_disp_page}, {2'h3, 4'(i)});
			push;
		end
		chk(o_disp_detail, 1'h0);
		test_done;
	end
	// Watchdog: the sequence needs well under 2000 cycles
	initial begin
		t(20000);
		n_errors++;
		test_done;
	end
endmodule
`default_nettype wire
